// *** verilog/ars_matrix.v ***
`timescale 1ns/1ns
`include "ars_map.vh"

// Notes on behaviour
// RL1 - any unit input may pick any source
// RL2 - source 0 is silence, adds nothing
// RL3 - unused inputs select silence, the reset default
// RL4 - sources 1 to 18 in fixed order
// RL5 - each unit has its own enable bit
// RL6 - speakerphone inputs are summation points
// RL7 - total attenuation is cancel plus suppress
// RL8 - suppress without cancel means half duplex
// RL9 - host keeps cancel off while recording/playing
// RL10 - suppress tops up what cancel lacks
// RL11 - sums saturate within one sample period
module ars_matrix #(
   parameter SW = 16,
   parameter NU = 8,
   parameter K = 3
) (
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire sample_stb,
   input wire [`ARS_NUM_SRC*SW-1:0] src_data,
   input wire [`ARS_ATT_W-1:0] gc_att,
   input wire [`ARS_ATT_W-1:0] gs_att,
   input wire rec_play_active,
   output reg [NU*SW-1:0] unit_in,
   output reg [SW-1:0] spk_mic_in,
   output reg [SW-1:0] spk_line_in,
   output reg [`ARS_NUM_UNIT-1:0] unit_en,
   output reg half_duplex,
   output reg [`ARS_ATT_W-1:0] supp_att_req,
   output reg [`ARS_ATT_W-1:0] total_speakerphone_attenuation,
   output reg ec_conflict
);
   localparam NSEL = NU + 2 * K;
   localparam AW = `ARS_ATT_W;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function [AW-1:0] att_add;
      input [AW-1:0] a;
      input [AW-1:0] b;
      reg [AW:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         // clip at the top code; a wrapped total would read as almost no attenuation
         att_add = s[AW] ? {AW{1'b1}} : s[AW-1:0];
      end
   endfunction

   function [9:0] word_of;
      input [11:0] ofs;
      begin
         word_of = ofs[11:2];
      end
   endfunction

   function [9:0] sel_word;
      input integer n;
      begin
         sel_word = word_of(`ARS_OFS_SEL_BASE) + n[9:0];
      end
   endfunction

   // shortfall of cancel against the request, never below zero
   function [AW-1:0] att_short;
      input [AW-1:0] need;
      input [AW-1:0] have;
      begin
         att_short = (need > have) ? need - have : {AW{1'b0}};
      end
   endfunction

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   reg [NSEL*`ARS_SEL_W-1:0] sel_q;
   reg [`ARS_NUM_UNIT-1:0] enable_q;
   reg [AW-1:0] att_req_q;
   wire ec_en;
   wire es_en;
   wire [9:0] word;
   wire setup_ok;
   wire do_write;
   reg [31:0] rd_d;
   reg hit_d;
   wire hit_enable;
   wire hit_att_req;
   wire hit_status;
   reg [`ARS_SEL_W-1:0] sel_rd;
   reg sel_hit;
   integer i;
   integer j;

   assign ec_en = enable_q[`ARS_EN_EC_BIT];
   assign es_en = enable_q[`ARS_EN_ES_BIT];
   assign word = word_of(paddr);
   // one wait state: pready rises the cycle after the access phase starts
   assign setup_ok = psel & penable & ~pready;
   // writes land only on the edge that shows pready, so a held request writes once
   assign do_write = psel & penable & pready & pwrite & hit_d;

   // -------------------------------------------------------------
   // address decode
   // -------------------------------------------------------------
   // status is read-only: a write there completes without error and changes nothing
   assign hit_enable = word == word_of(`ARS_OFS_ENABLE);
   assign hit_att_req = word == word_of(`ARS_OFS_ATT_REQ);
   assign hit_status = word == word_of(`ARS_OFS_STATUS);

   // -------------------------------------------------------------
   // speakerphone attenuation
   // -------------------------------------------------------------
   wire [AW-1:0] total_d;
   reg [AW-1:0] supp_d;
   assign total_d = att_add(gc_att, gs_att); // see RL7

   always @* begin
      if (!es_en) begin
         supp_d = {AW{1'b0}};
      end else if (!ec_en) begin
         supp_d = att_req_q; // see RL8
      end else begin
         supp_d = att_short(att_req_q, gc_att); // see RL10
      end
   end

   // -------------------------------------------------------------
   // selector readback
   // -------------------------------------------------------------
   always @* begin
      sel_rd = {`ARS_SEL_W{1'b0}};
      sel_hit = 1'b0;
      for (i = 0; i < NSEL; i = i + 1) begin
         if (word == sel_word(i)) begin
            sel_hit = 1'b1;
            sel_rd = sel_q[i*`ARS_SEL_W +: `ARS_SEL_W];
         end
      end
   end

   // -------------------------------------------------------------
   // read decode
   // -------------------------------------------------------------
   always @* begin
      rd_d = 32'h0000_0000;
      hit_d = 1'b0;
      if (hit_enable) begin
         hit_d = 1'b1;
         rd_d[`ARS_NUM_UNIT-1:0] = enable_q;
      end else if (hit_att_req) begin
         hit_d = 1'b1;
         rd_d[AW-1:0] = att_req_q;
      end else if (hit_status) begin
         hit_d = 1'b1;
         rd_d[`ARS_ST_TOTAL_LSB +: AW] = total_speakerphone_attenuation;
         rd_d[`ARS_ST_GC_LSB +: AW] = gc_att;
         rd_d[`ARS_ST_GS_LSB +: AW] = gs_att;
         rd_d[`ARS_ST_HDX_BIT] = half_duplex;
         rd_d[`ARS_ST_CONFLICT_BIT] = ec_conflict;
      end else if (sel_hit) begin
         hit_d = 1'b1;
         rd_d[`ARS_SEL_W-1:0] = sel_rd;
      end
   end

   // -------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup_ok;
         pslverr <= setup_ok & ~hit_d;
         // loaded with pready, so prdata is steady on the edge the master takes it
         if (setup_ok && !pwrite) begin
            prdata <= rd_d;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= `ARS_ENABLE_RST;
      end else if (do_write && hit_enable) begin
         enable_q <= pwdata[`ARS_NUM_UNIT-1:0]; // see RL5
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         att_req_q <= `ARS_ATT_REQ_RST;
      end else if (do_write && hit_att_req) begin
         att_req_q <= pwdata[AW-1:0];
      end
   end

   // a selector write changes one route only; the others keep their source mid-call
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= {NSEL{`ARS_SEL_RST}}; // see RL3
      end else if (do_write) begin
         for (j = 0; j < NSEL; j = j + 1) begin
            if (word == sel_word(j)) begin
               sel_q[j*`ARS_SEL_W +: `ARS_SEL_W] <= pwdata[`ARS_SEL_W-1:0]; // see RL1
            end
         end
      end
   end

   // -------------------------------------------------------------
   // routing: plain inputs first, then mic terms, then line terms
   // -------------------------------------------------------------
   wire [NSEL*SW-1:0] picked;
   wire [SW-1:0] mic_sum;
   wire [SW-1:0] line_sum;

   genvar g;
   generate
      for (g = 0; g < NSEL; g = g + 1) begin : gen_sel
         ars_src_mux #(
            .SW(SW),
            .NSRC(`ARS_NUM_SRC)
         ) u_mux (
            .src(src_data), // see RL4
            .sel(sel_q[g*`ARS_SEL_W +: `ARS_SEL_W]),
            .dout(picked[g*SW +: SW])
         );
      end
   endgenerate

   ars_sat_sum #(
      .SW(SW),
      .K(K)
   ) u_mic_sum (
      .terms(picked[NU*SW +: K*SW]), // see RL6
      .sum(mic_sum)
   );

   ars_sat_sum #(
      .SW(SW),
      .K(K)
   ) u_line_sum (
      .terms(picked[(NU+K)*SW +: K*SW]), // see RL6
      .sum(line_sum)
   );

   // -------------------------------------------------------------
   // sample-rate outputs
   // -------------------------------------------------------------
   // all routes update together on the strobe, so no unit sees a mix of two periods
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_in <= {(NU*SW){1'b0}};
      end else if (sample_stb) begin
         unit_in <= picked[NU*SW-1:0];
      end
   end

   // both speakerphone sides take the same strobe so they stay sample-aligned
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spk_mic_in <= {SW{1'b0}};
         spk_line_in <= {SW{1'b0}};
      end else if (sample_stb) begin
         spk_mic_in <= mic_sum; // see RL11
         spk_line_in <= line_sum; // see RL11
      end
   end

   // -------------------------------------------------------------
   // control outputs
   // -------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_en <= `ARS_ENABLE_RST;
         half_duplex <= 1'b0;
         supp_att_req <= {AW{1'b0}};
         total_speakerphone_attenuation <= {AW{1'b0}};
         ec_conflict <= 1'b0;
      end else begin
         unit_en <= enable_q; // see RL5
         half_duplex <= es_en & ~ec_en; // see RL8
         supp_att_req <= supp_d; // see RL10
         total_speakerphone_attenuation <= total_d; // see RL7
         // cancel is not forced off; software is told so it can fix it
         ec_conflict <= ec_en & rec_play_active; // see RL9
      end
   end
endmodule // ars_matrix

// *** verilog/ars_map.vh ***
`ifndef ARS_MAP_VH
`define ARS_MAP_VH
// -------------------------------------------------------------
// register offsets (byte addresses, one word each)
// -------------------------------------------------------------
`define ARS_OFS_ENABLE 12'h000
`define ARS_OFS_ATT_REQ 12'h004
`define ARS_OFS_STATUS 12'h008
`define ARS_OFS_SEL_BASE 12'h040
// -------------------------------------------------------------
// sources and fields
// -------------------------------------------------------------
`define ARS_NUM_SRC 18
`define ARS_SRC_SILENCE 5'h00
`define ARS_SEL_W 5
`define ARS_SEL_RST 5'h00
`define ARS_NUM_UNIT 12
`define ARS_ENABLE_RST 12'h000
`define ARS_EN_EC_BIT 5
`define ARS_EN_ES_BIT 6
`define ARS_ATT_W 8
`define ARS_ATT_REQ_RST 8'h00
`define ARS_ST_TOTAL_LSB 0
`define ARS_ST_GC_LSB 8
`define ARS_ST_GS_LSB 16
`define ARS_ST_HDX_BIT 24
`define ARS_ST_CONFLICT_BIT 25
`endif

// *** verilog/ars_src_mux.v ***
`timescale 1ns/1ns
`include "ars_map.vh"
// picks one of the sources; index 0 and any index past the last source give silence
module ars_src_mux #(
   parameter SW = 16,
   parameter NSRC = `ARS_NUM_SRC
) (
   input wire [NSRC*SW-1:0] src,
   input wire [`ARS_SEL_W-1:0] sel,
   output reg [SW-1:0] dout
);
   integer i;
   always @* begin
      dout = {SW{1'b0}}; // see RL2
      for (i = 1; i <= NSRC; i = i + 1) begin
         if (sel == i[`ARS_SEL_W-1:0]) begin
            dout = src[(i-1)*SW +: SW]; // see RL1
         end
      end
   end
endmodule // ars_src_mux

// *** verilog/ars_sat_sum.v ***
`timescale 1ns/1ns
// adds K signed samples, clipping to the sample range instead of wrapping
module ars_sat_sum #(
   parameter SW = 16,
   parameter K = 3
) (
   input wire [K*SW-1:0] terms,
   output reg [SW-1:0] sum
);
   localparam GW = 4;
   integer i;
   reg signed [SW+GW-1:0] acc;
   reg [SW-1:0] t;
   always @* begin
      acc = {(SW+GW){1'b0}};
      t = {SW{1'b0}};
      for (i = 0; i < K; i = i + 1) begin
         t = terms[i*SW +: SW];
         acc = acc + $signed({{GW{t[SW-1]}}, t});
      end
      if (acc > $signed({{(GW+1){1'b0}}, {(SW-1){1'b1}}})) begin
         sum = {1'b0, {(SW-1){1'b1}}}; // see RL11
      end else if (acc < $signed({{(GW+1){1'b1}}, {(SW-1){1'b0}}})) begin
         sum = {1'b1, {(SW-1){1'b0}}}; // see RL11
      end else begin
         sum = acc[SW-1:0];
      end
   end
endmodule // ars_sat_sum

// *** tb/ars_monitor.sv ***
`timescale 1ns/1ns
`include "ars_map.vh"
// ----------------
// port checker
// ----------------
module ars_monitor #(
   parameter SW = 16,
   parameter NU = 8
) (
   input wire pclk,
   input wire presetn,
   input wire pready,
   input wire pslverr,
   input wire sample_stb,
   input wire [`ARS_NUM_SRC*SW-1:0] src_data,
   input wire [`ARS_ATT_W-1:0] gc_att,
   input wire [`ARS_ATT_W-1:0] gs_att,
   input wire rec_play_active,
   input wire [NU*SW-1:0] unit_in,
   input wire [SW-1:0] spk_mic_in,
   input wire [SW-1:0] spk_line_in,
   input wire [`ARS_NUM_UNIT-1:0] unit_en,
   input wire half_duplex,
   input wire [`ARS_ATT_W-1:0] supp_att_req,
   input wire [`ARS_ATT_W-1:0] total_speakerphone_attenuation,
   input wire ec_conflict
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg [`ARS_NUM_UNIT-1:0] en_q;
   reg [`ARS_NUM_UNIT-1:0] en2_q;
   wire [8:0] att_sum = gc_att + gs_att;
   // enables unchanged for three clocks, so any register lag has settled
   wire calm = unit_en == en_q && en_q == en2_q;
   always @(posedge pclk) begin
      en_q <= unit_en;
      en2_q <= en_q;
   end
   property p_total;
      $past(presetn) |-> total_speakerphone_attenuation == $past(att_sum[8] ? 8'hff : att_sum[7:0]);
   endproperty
   a_total: assert property (p_total) else $error("total attenuation wrong");
   property p_hdx;
      calm |-> half_duplex == (unit_en[6] & ~unit_en[5]);
   endproperty
   a_hdx: assert property (p_hdx) else $error("half duplex wrong");
   property p_conf;
      calm && $stable(rec_play_active) |-> ec_conflict == (unit_en[5] & rec_play_active);
   endproperty
   a_conf: assert property (p_conf) else $error("conflict flag wrong");
   property p_supp;
      calm && !unit_en[6] |-> supp_att_req == 8'h00;
   endproperty
   a_supp: assert property (p_supp) else $error("suppress request while off");
   property p_hold;
      $past(presetn) && !$past(sample_stb) |-> $stable(unit_in) && $stable(spk_mic_in) && $stable(spk_line_in);
   endproperty
   a_hold: assert property (p_hold) else $error("routed output moved off strobe");
   property p_silence;
      sample_stb && src_data == 0 |=> unit_in == 0 && spk_mic_in == 0 && spk_line_in == 0;
   endproperty
   a_silence: assert property (p_silence) else $error("silence not zero");
   property p_sat;
      sample_stb && src_data == {`ARS_NUM_SRC{16'h7000}} |=> !spk_mic_in[SW-1];
   endproperty
   a_sat: assert property (p_sat) else $error("sum wrapped");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pready too long");
   c_stb: cover property (sample_stb);
   c_err: cover property (pready && pslverr);
   c_hdx: cover property (half_duplex);
endmodule // ars_monitor
bind ars_matrix ars_monitor #(.SW(SW), .NU(NU)) u_mon (.pclk, .presetn, .pready, .pslverr, .sample_stb,
   .src_data, .gc_att, .gs_att, .rec_play_active, .unit_in, .spk_mic_in, .spk_line_in, .unit_en,
   .half_duplex, .supp_att_req, .total_speakerphone_attenuation, .ec_conflict);

// *** tb/ars_unit_model.sv ***
`timescale 1ns/1ns
// ----------------
// far-side units: in mode 0 each source carries a value naming it
// ----------------
module ars_unit_model (
   input wire [1:0] mode,
   input wire [7:0] gc,
   input wire [7:0] gs,
   input wire rec,
   output reg [287:0] src_data,
   output wire [7:0] gc_att,
   output wire [7:0] gs_att,
   output wire rec_play_active
);
   integer n;
   assign gc_att = gc;
   assign gs_att = gs;
   assign rec_play_active = rec;
   always @* begin
      for (n = 0; n < 18; n = n + 1) begin
         case (mode)
            2'h0: src_data[n*16 +: 16] = (n[15:0] + 16'h0001) * 16'h0111;
            2'h1: src_data[n*16 +: 16] = 16'h7000;
            2'h2: src_data[n*16 +: 16] = 16'h9000;
            default: src_data[n*16 +: 16] = 16'h0000;
         endcase
      end
   end
endmodule // ars_unit_model

// *** tb/audio_signal_routing_matrix_bench.sv ***
`timescale 1ns/1ns
`include "ars_map.vh"
module audio_signal_routing_matrix_bench;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_stb = 0, rec = 0, e;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, r;
   reg [1:0] mode = 0;
   reg [7:0] gc = 0, gs = 0;
   wire [31:0] prdata;
   wire pready, pslverr, half_duplex, ec_conflict, rec_play_active;
   wire [287:0] src_data;
   wire [7:0] gc_att, gs_att, supp_att_req, total_speakerphone_attenuation;
   wire [127:0] unit_in;
   wire [15:0] spk_mic_in, spk_line_in;
   wire [11:0] unit_en;
   integer num_errors = 0, tests_run = 0, i, p;
   ars_unit_model u_far (.mode, .gc, .gs, .rec, .src_data, .gc_att, .gs_att, .rec_play_active);
   ars_matrix u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .sample_stb, .src_data, .gc_att, .gs_att, .rec_play_active, .unit_in, .spk_mic_in,
      .spk_line_in, .unit_en, .half_duplex, .supp_att_req, .total_speakerphone_attenuation, .ec_conflict);
   function [31:0] pat(input integer n);
      pat = n * 32'h0111;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task xfer(input integer a, input w, input integer d);
      begin
         @(posedge pclk);
         paddr <= a[11:0];
         pwrite <= w;
         pwdata <= d;
         psel <= 1'b1;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // no local limit: only the watchdog ends a wait that never sees pready
         while (pready !== 1'b1) begin
            @(posedge pclk);
         end
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rd(input integer a, input [31:0] exp);
      begin
         xfer(a, 1'b0, 0);
         chk(r, exp);
      end
   endtask
   task strobe;
      begin
         @(posedge pclk);
         sample_stb <= 1'b1;
         @(posedge pclk);
         sample_stb <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task spk(input integer en, input integer req, input [31:0] st, input [7:0] sup);
      begin
         xfer(`ARS_OFS_ENABLE, 1'b1, en);
         xfer(`ARS_OFS_ATT_REQ, 1'b1, req);
         rd(`ARS_OFS_STATUS, st);
         chk({24'h0, supp_att_req}, {24'h0, sup});
      end
   endtask
   task conclude;
      begin
         if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      forever #5 pclk = ~pclk;
   end
   initial begin
      #50000;
      num_errors = num_errors + 1;
      conclude;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ARS_OFS_ENABLE, 0);
      rd(`ARS_OFS_SEL_BASE + 28, 0);
      strobe;
      chk(unit_in[31:0], 0);
      // ---------
      // source indices 1 to 24, three per plain input; past 18 is silence
      // ---------
      for (p = 0; p < 3; p = p + 1) begin
         for (i = 0; i < 8; i = i + 1)
            xfer(`ARS_OFS_SEL_BASE + 4 * i, 1'b1, p * 8 + i + 1);
         rd(`ARS_OFS_SEL_BASE + 4, p * 8 + 2);
         strobe;
         for (i = 0; i < 8; i = i + 1)
            chk({16'h0, unit_in[i*16 +: 16]}, p * 8 + i < 18 ? pat(p * 8 + i + 1) : 0);
      end
      // unused sum terms stay on silence
      for (i = 0; i < 6; i = i + 1)
         xfer(`ARS_OFS_SEL_BASE + 32 + 4 * i, 1'b1, i < 3 ? i + 1 : (i == 4 ? 4 : 0));
      strobe;
      chk({16'h0, spk_mic_in}, pat(1) + pat(2) + pat(3));
      chk({16'h0, spk_line_in}, pat(4));
      for (p = 1; p < 4; p = p + 1) begin
         @(posedge pclk);
         mode <= p[1:0];
         strobe;
         chk({16'h0, spk_mic_in}, p == 1 ? 32'h7fff : p == 2 ? 32'h8000 : 0);
         chk({16'h0, spk_line_in}, p == 1 ? 32'h7000 : p == 2 ? 32'h9000 : 0);
      end
      for (i = 0; i < 12; i = i + 1) begin
         xfer(`ARS_OFS_ENABLE, 1'b1, 1 << i);
         rd(`ARS_OFS_ENABLE, 1 << i);
         chk({20'h0, unit_en}, 1 << i);
      end
      @(posedge pclk);
      gc <= 8'h30;
      gs <= 8'h20;
      rec <= 1'b1;
      // cancel kept off while recording
      spk(32'h40, 32'h50, 32'h01203050, 8'h50);
      @(posedge pclk);
      rec <= 1'b0;
      spk(32'h60, 32'h50, 32'h00203050, 8'h20);
      spk(32'h60, 32'h20, 32'h00203050, 8'h00);
      @(posedge pclk);
      gc <= 8'hf0;
      spk(32'h60, 32'h20, 32'h0020f0ff, 8'h00);
      xfer(`ARS_OFS_STATUS, 1'b1, -1);
      chk({31'h0, e}, 0);
      rd(`ARS_OFS_STATUS, 32'h0020f0ff);
      xfer(12'h100, 1'b0, 0);
      chk(r, 0);
      chk({31'h0, e}, 1);
      conclude;
   end
endmodule // audio_signal_routing_matrix_bench
